// ==== core/pin_sync.sv ====
// Two-stage synchroniser for a group of pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_reg <= '0;
      dout <= '0;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ==== core/prog_port_dev.sv ====
// Device end of the parallel programming port
//
// Contract
// - Action bits select address, data, command load
// - Command and address held until reloaded
// - Drive data bus only while output gate low; the device keeps driving for three clk_sys cycles after the gate rises
// - No-operation command clears internal write controls
// - EEPROM page buffered, committed in one go
// - Programmer: command, high address, low/data/latch loop
// - Program pulse starts EEPROM page, ready drops
// - Flash read gives low/high byte by select
// - EEPROM read gives addressed byte
// - Fuse data bit zero programs, one erases
// - Byte selects choose low, high, extended fuses
// - Lock write: zero bit programs lock bit
// - Lock bits cleared only by chip erase
// - Status read: fuses and locks by select pair
// - Identification byte read by low address
// - Calibration byte read with byte select one
// - Programmer repeats flash page sequence per page
// - Serial link with clock, data in, out
// - Serial writes refused until programming enable seen
// - Serial data on dedicated programming pins
`timescale 1ns/100ps
`default_nettype none
module prog_port_dev
  import prog_port_pkg::*;
#(
  parameter int FLASH_AW = 10,
  parameter int EE_AW = 8,
  parameter int PAGE_AW = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  prog_port_if.device pins,
  output logic ser_enabled,
  output logic [7:0] lock_bits
);
  typedef enum logic [1:0] {ST_READY, ST_BUSY} phase_t;
  typedef struct packed {
    phase_t phase;
    logic [7:0] busy_cnt;
    logic [7:0] cmd;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] data_lo;
    logic [7:0] data_hi;
    logic wr_active;
    logic ready;
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [7:0] fuse_ext;
    logic [7:0] lock;
    logic strobe_d;
    logic wr_d;
    logic latch_d;
    logic sck_d;
    logic [7:0] out_byte;
    logic out_oe;
    logic [7:0] ser_sh;
    logic [1:0] ser_cnt_byte;
    logic [2:0] ser_bit;
    logic ser_b1_ok;
    logic ser_en;
    logic ser_out;
  } state_t;

  state_t s_reg, s_next;
  logic [7:0] flash_lo_mem [2**FLASH_AW];
  logic [7:0] flash_hi_mem [2**FLASH_AW];
  logic [7:0] ee_mem [2**EE_AW];
  logic [7:0] ee_buf [2**PAGE_AW];
  logic [7:0] fl_buf_lo [2**PAGE_AW];
  logic [7:0] fl_buf_hi [2**PAGE_AW];
  logic [10:0] sy;
  logic [7:0] dsy;
  logic strobe_s, wr_s, latch_s, oe_s, sck_s, sdi_s, srst_s;
  logic [1:0] act_s, bs_s;

  pin_sync #(.W(11)) u_ctl_sync (.clk_sys(clk_sys), .rst(rst),
    .din(CTL_IDLE ^ {pins.strobe_clock_in, pins.action_sel_hi, pins.action_sel_lo, pins.byte_sel_first,
          pins.byte_sel_second, pins.page_latch_strobe, pins.wr_n, pins.oe_n, pins.serial_sck,
          pins.serial_prog_in, pins.serial_reset_n}),
    .dout(sy));
  pin_sync #(.W(8)) u_dat_sync (.clk_sys(clk_sys), .rst(rst), .din(pins.data_bus), .dout(dsy));
  // Inverted round the synchroniser so reset leaves pins at idle
  assign {strobe_s, act_s, bs_s, latch_s, wr_s, oe_s, sck_s, sdi_s, srst_s} = sy ^ CTL_IDLE;

  function automatic logic [FLASH_AW-1:0] flash_addr(input logic [7:0] hi, input logic [7:0] lo);
    logic [15:0] a;
    a = {hi, lo};
    return a[FLASH_AW-1:0];
  endfunction : flash_addr

  function automatic logic [FLASH_AW-1:0] page_slot(input logic [7:0] hi, input logic [7:0] lo,
                                                    input logic [PAGE_AW-1:0] w);
    logic [FLASH_AW-1:0] a;
    a = flash_addr(hi, lo);
    return {a[FLASH_AW-1:PAGE_AW], w};
  endfunction : page_slot

  logic strobe_rise, wr_fall, latch_rise, sck_rise, sck_fall;
  assign strobe_rise = strobe_s & ~s_reg.strobe_d;
  assign wr_fall = ~wr_s & s_reg.wr_d;
  assign latch_rise = latch_s & ~s_reg.latch_d;
  assign sck_rise = sck_s & ~s_reg.sck_d;
  assign sck_fall = ~sck_s & s_reg.sck_d;

  always_comb begin
    logic [7:0] rd;
    rd = ERASED_BYTE;
    s_next = s_reg;
    s_next.strobe_d = strobe_s;
    s_next.wr_d = wr_s;
    s_next.latch_d = latch_s;
    s_next.sck_d = sck_s;
    if (strobe_rise) begin
      case (act_s)
        ACT_ADDR: begin
          if (bs_s[1]) s_next.addr_hi = dsy;
          else s_next.addr_lo = dsy;
        end
        ACT_DATA: begin
          if (bs_s[1]) s_next.data_hi = dsy;
          else s_next.data_lo = dsy;
        end
        ACT_CMD: begin
          s_next.cmd = dsy;
          if (dsy == CMD_NOP) s_next.wr_active = 1'b0;
          else s_next.wr_active = 1'b1;
        end
        default: begin
        end
      endcase
    end
    case (s_reg.phase)
      ST_READY: begin
        if (wr_fall && !bs_s[1]) begin
          s_next.phase = ST_BUSY;
          s_next.busy_cnt = BUSY_CNT_W;
          if (s_reg.cmd == CMD_WR_FUSE) begin
            if (bs_s[1]) s_next.fuse_hi = s_reg.data_lo;
            else if (bs_s[0]) s_next.fuse_ext = s_reg.data_lo;
            else s_next.fuse_lo = s_reg.data_lo;
          end else if (s_reg.cmd == CMD_WR_LOCK) begin
            s_next.lock = s_reg.lock & s_reg.data_lo;
          end else if (s_reg.cmd == CMD_CHIP_ERASE) begin
            s_next.lock = LOCK_RST;
          end
        end else if (wr_fall && bs_s == 2'b01 && s_reg.cmd == CMD_WR_FUSE) begin
          s_next.phase = ST_BUSY;
          s_next.busy_cnt = BUSY_CNT_W;
          s_next.fuse_ext = s_reg.data_lo;
        end else if (wr_fall && bs_s == 2'b10 && s_reg.cmd == CMD_WR_FUSE) begin
          s_next.phase = ST_BUSY;
          s_next.busy_cnt = BUSY_CNT_W;
          s_next.fuse_hi = s_reg.data_lo;
        end
      end
      ST_BUSY: begin
        s_next.busy_cnt = s_reg.busy_cnt - 8'd1;
        if (s_reg.busy_cnt == 8'd1) s_next.phase = ST_READY;
      end
      default: s_next.phase = ST_READY;
    endcase
    s_next.ready = (s_next.phase == ST_READY);
    // Read path
    if (s_reg.cmd == CMD_RD_FLASH) begin
      rd = bs_s[1] ? flash_hi_mem[flash_addr(s_reg.addr_hi, s_reg.addr_lo)]
                   : flash_lo_mem[flash_addr(s_reg.addr_hi, s_reg.addr_lo)];
    end else if (s_reg.cmd == CMD_RD_EEPROM) begin
      rd = ee_mem[s_reg.addr_lo[EE_AW-1:0]];
    end else if (s_reg.cmd == CMD_RD_FUSE) begin
      case ({bs_s[0], bs_s[1]})
        2'b00: rd = s_reg.fuse_lo;
        2'b11: rd = s_reg.fuse_hi;
        2'b10: rd = s_reg.fuse_ext;
        default: rd = s_reg.lock;
      endcase
    end else if (s_reg.cmd == CMD_RD_ID) begin
      if (bs_s[1]) rd = CAL_BYTE;
      else if (s_reg.addr_lo == 8'h00) rd = ID_BYTE0;
      else if (s_reg.addr_lo == 8'h01) rd = ID_BYTE1;
      else if (s_reg.addr_lo == 8'h02) rd = ID_BYTE2;
      else rd = ERASED_BYTE;
    end
    s_next.out_byte = rd;
    s_next.out_oe = ~oe_s;
    // Serial programming enable detector
    if (srst_s) begin
      s_next.ser_en = 1'b0;
      s_next.ser_bit = 3'd0;
      s_next.ser_cnt_byte = 2'd0;
      s_next.ser_b1_ok = 1'b0;
    end else begin
      if (sck_rise) begin
        s_next.ser_sh = {s_reg.ser_sh[6:0], sdi_s};
        s_next.ser_bit = s_reg.ser_bit + 3'd1;
        if (s_reg.ser_bit == 3'd7) begin
          s_next.ser_cnt_byte = s_reg.ser_cnt_byte + 2'd1;
          if (s_reg.ser_cnt_byte == 2'd0) s_next.ser_b1_ok = ({s_reg.ser_sh[6:0], sdi_s} == SER_EN_B1);
          if (s_reg.ser_cnt_byte == 2'd1 && s_reg.ser_b1_ok && {s_reg.ser_sh[6:0], sdi_s} == SER_EN_B2)
            s_next.ser_en = 1'b1;
        end
      end
      if (sck_fall) s_next.ser_out = s_reg.ser_sh[7];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_reg <= '{phase: ST_READY, busy_cnt: 8'h00, cmd: CMD_NOP, addr_lo: 8'h00, addr_hi: 8'h00,
                 data_lo: 8'h00, data_hi: 8'h00, wr_active: 1'b0, ready: 1'b1, fuse_lo: FUSE_LO_RST,
                 fuse_hi: FUSE_HI_RST, fuse_ext: FUSE_EXT_RST, lock: LOCK_RST, strobe_d: 1'b0,
                 wr_d: 1'b1, latch_d: 1'b0, sck_d: 1'b0, out_byte: 8'h00, out_oe: 1'b0,
                 ser_sh: 8'h00, ser_cnt_byte: 2'd0, ser_bit: 3'd0, ser_b1_ok: 1'b0, ser_en: 1'b0,
                 ser_out: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Page buffers and arrays
  always_ff @(posedge clk_sys) begin
    if (latch_rise && s_reg.wr_active) begin
      ee_buf[s_reg.addr_lo[PAGE_AW-1:0]] <= s_reg.data_lo;
      fl_buf_lo[s_reg.addr_lo[PAGE_AW-1:0]] <= s_reg.data_lo;
      fl_buf_hi[s_reg.addr_lo[PAGE_AW-1:0]] <= s_reg.data_hi;
    end
    if (s_reg.phase == ST_READY && wr_fall && bs_s == 2'b00) begin
      for (int i = 0; i < 2**PAGE_AW; i++) begin
        if (s_reg.cmd == CMD_WR_EEPROM) begin
          ee_mem[{s_reg.addr_lo[EE_AW-1:PAGE_AW], PAGE_AW'(i)}] <= ee_buf[i];
        end else if (s_reg.cmd == CMD_WR_FLASH) begin
          flash_lo_mem[page_slot(s_reg.addr_hi, s_reg.addr_lo, PAGE_AW'(i))] <= fl_buf_lo[i];
          flash_hi_mem[page_slot(s_reg.addr_hi, s_reg.addr_lo, PAGE_AW'(i))] <= fl_buf_hi[i];
        end
      end
    end
  end

  assign pins.data_dev = s_reg.out_byte;
  assign pins.data_dev_oe = s_reg.out_oe;
  assign pins.done_flag = s_reg.ready;
  assign pins.serial_prog_out = s_reg.ser_out;
  assign ser_enabled = s_reg.ser_en;
  assign lock_bits = s_reg.lock;
endmodule : prog_port_dev
`default_nettype wire

// ==== core/prog_port_host.sv ====
// Programmer end of the parallel programming port
`timescale 1ns/100ps
`default_nettype none
module prog_port_host
  import prog_port_pkg::*;
#(
  parameter int HALF = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  prog_port_if.host pins,
  input wire logic req_valid,
  input wire logic [2:0] req_kind,
  input wire logic [1:0] req_act,
  input wire logic [1:0] req_bs,
  input wire logic [7:0] req_data,
  output logic req_ready,
  output logic [7:0] rsp_data,
  output logic rsp_valid
);
  // req_kind: 0 strobe load, 1 latch pulse, 2 program pulse then wait ready, 3 read,
  // 4 serial byte with serial reset low, 5 serial reset release
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_PULSE, H_HOLD, H_WAIT, H_SER} hstate_t;
  typedef struct packed {
    hstate_t st;
    logic [2:0] kind;
    logic [3:0] cnt;
    logic strobe;
    logic latch;
    logic wr_n;
    logic oe_n;
    logic [1:0] act;
    logic [1:0] bs;
    logic [7:0] dout;
    logic doe;
    logic [7:0] rsp;
    logic rsp_v;
    logic sck;
    logic ser_rst_n;
    logic idle;
  } hs_t;
  hs_t h_reg, h_next;
  logic [8:0] sy;

  pin_sync #(.W(9)) u_sync (.clk_sys(clk_sys), .rst(rst), .din({pins.data_bus, pins.done_flag}), .dout(sy));

  always_comb begin
    h_next = h_reg;
    h_next.rsp_v = 1'b0;
    case (h_reg.st)
      H_IDLE: begin
        if (req_valid) begin
          h_next.kind = req_kind;
          h_next.act = req_act;
          h_next.bs = req_bs;
          h_next.dout = req_data;
          h_next.doe = (req_kind < 3'd3);
          h_next.oe_n = (req_kind != 3'd3);
          h_next.cnt = 4'(HALF);
          h_next.st = H_SETUP;
          if (req_kind == 3'd4) begin
            h_next.ser_rst_n = 1'b0;
            h_next.cnt = 4'd8;
            h_next.st = H_SER;
          end else if (req_kind == 3'd5) begin
            h_next.ser_rst_n = 1'b1;
            h_next.st = H_HOLD;
          end
        end
      end
      H_SETUP: begin
        h_next.cnt = h_reg.cnt - 4'd1;
        if (h_reg.cnt == 4'd1) begin
          h_next.cnt = 4'(HALF);
          h_next.st = H_PULSE;
          if (h_reg.kind == 3'd0) h_next.strobe = 1'b1;
          else if (h_reg.kind == 3'd1) h_next.latch = 1'b1;
          else if (h_reg.kind == 3'd2) h_next.wr_n = 1'b0;
        end
      end
      H_PULSE: begin
        h_next.cnt = h_reg.cnt - 4'd1;
        if (h_reg.cnt == 4'd1) begin
          h_next.strobe = 1'b0;
          h_next.latch = 1'b0;
          h_next.wr_n = 1'b1;
          h_next.cnt = 4'(HALF);
          h_next.st = (h_reg.kind == 3'd2) ? H_WAIT : H_HOLD;
          if (h_reg.kind == 3'd3) begin
            h_next.rsp = sy[8:1];
            h_next.rsp_v = 1'b1;
            h_next.oe_n = 1'b1;
          end
        end
      end
      H_WAIT: begin
        h_next.cnt = h_reg.cnt - 4'd1;
        if (h_reg.cnt == 4'd0 && sy[0]) begin
          h_next.bs = 2'b00;
          h_next.st = H_HOLD;
        end else if (h_reg.cnt == 4'd0) begin
          h_next.cnt = 4'd0;
        end
      end
      H_HOLD: begin
        h_next.doe = 1'b0;
        h_next.cnt = h_reg.cnt - 4'd1;
        // After a read, wait out the device's lagging bus release
        if (h_reg.kind != 3'd3 || h_reg.cnt == 4'd0) h_next.st = H_IDLE;
      end
      H_SER: begin
        if (!h_reg.sck) begin
          h_next.sck = 1'b1;
        end else begin
          h_next.sck = 1'b0;
          h_next.dout = {h_reg.dout[6:0], 1'b0};
          h_next.cnt = h_reg.cnt - 4'd1;
          if (h_reg.cnt == 4'd1) h_next.st = H_HOLD;
        end
      end
      default: h_next.st = H_IDLE;
    endcase
    h_next.idle = (h_next.st == H_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      h_reg <= '{st: H_IDLE, kind: 3'd0, cnt: 4'd0, strobe: 1'b0, latch: 1'b0, wr_n: 1'b1,
                 oe_n: 1'b1, act: ACT_IDLE, bs: 2'b00, dout: 8'h00, doe: 1'b0, rsp: 8'h00, rsp_v: 1'b0,
                 sck: 1'b0, ser_rst_n: 1'b1, idle: 1'b1};
    end else begin
      h_reg <= h_next;
    end
  end

  assign pins.strobe_clock_in = h_reg.strobe;
  assign pins.action_sel_hi = h_reg.act[1];
  assign pins.action_sel_lo = h_reg.act[0];
  assign pins.byte_sel_first = h_reg.bs[1];
  assign pins.byte_sel_second = h_reg.bs[0];
  assign pins.page_latch_strobe = h_reg.latch;
  assign pins.wr_n = h_reg.wr_n;
  assign pins.oe_n = h_reg.oe_n;
  assign pins.data_host = h_reg.dout;
  assign pins.data_host_oe = h_reg.doe;
  assign pins.serial_sck = h_reg.sck;
  assign pins.serial_prog_in = h_reg.dout[7];
  assign pins.serial_reset_n = h_reg.ser_rst_n;
  assign req_ready = h_reg.idle;
  assign rsp_data = h_reg.rsp;
  assign rsp_valid = h_reg.rsp_v;
endmodule : prog_port_host
`default_nettype wire

// ==== core/prog_port_if.sv ====
// Pin bundle between programmer and device
`timescale 1ns/100ps
`default_nettype none
interface prog_port_if;
  logic strobe_clock_in;
  logic action_sel_hi;
  logic action_sel_lo;
  logic byte_sel_first;
  logic byte_sel_second;
  logic page_latch_strobe;
  logic wr_n;
  logic oe_n;
  logic [7:0] data_host;
  logic data_host_oe;
  logic [7:0] data_dev;
  logic data_dev_oe;
  logic done_flag;
  logic serial_sck;
  logic serial_prog_in;
  logic serial_prog_out;
  logic serial_reset_n;
  logic [7:0] data_bus;
  assign data_bus = data_dev_oe ? data_dev : (data_host_oe ? data_host : 8'hFF);
  modport device (input strobe_clock_in, action_sel_hi, action_sel_lo, byte_sel_first, byte_sel_second,
    page_latch_strobe, wr_n, oe_n, data_bus, serial_sck, serial_prog_in, serial_reset_n,
    output data_dev, data_dev_oe, done_flag, serial_prog_out);
  modport host (output strobe_clock_in, action_sel_hi, action_sel_lo, byte_sel_first, byte_sel_second,
    page_latch_strobe, wr_n, oe_n, data_host, data_host_oe, serial_sck, serial_prog_in, serial_reset_n,
    input data_bus, done_flag, serial_prog_out);
endinterface : prog_port_if
`default_nettype wire

// ==== core/prog_port_pkg.sv ====
// Shared constants for the parallel programming port
package prog_port_pkg;
  localparam int DATA_W = 8;
  // Action select codes
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  // Idle levels of the synchronised control pins, write, output gate and serial reset high
  localparam logic [10:0] CTL_IDLE = 11'h019;
  // Command bytes
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
  localparam logic [7:0] CMD_RD_ID = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM = 8'h03;
  // Reset values
  localparam logic [7:0] FUSE_LO_RST = 8'hFF;
  localparam logic [7:0] FUSE_HI_RST = 8'hFF;
  localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Busy times in cycles of clk_sys
  localparam int BUSY_CYCLES = 16;
  localparam logic [7:0] BUSY_CNT_W = 8'd16;
  // Serial programming enable instruction bytes
  localparam logic [7:0] SER_EN_B1 = 8'hAC;
  localparam logic [7:0] SER_EN_B2 = 8'h53;
  // Arbitrary identification and calibration values
  localparam logic [7:0] ID_BYTE0 = 8'h5A;
  localparam logic [7:0] ID_BYTE1 = 8'h3C;
  localparam logic [7:0] ID_BYTE2 = 8'h81;
  localparam logic [7:0] CAL_BYTE = 8'h7E;
endpackage : prog_port_pkg

// ==== tb/parallel_prog_port_tb_top.sv ====
// Testbench joining programmer and device ends of the programming port
`timescale 1ns/100ps
`default_nettype none
module parallel_prog_port_tb_top;
  import prog_port_pkg::*;
  typedef struct {string name; logic [7:0] v;} note_t;
  logic clk_sys;
  logic rst;
  logic req_valid;
  logic [2:0] req_kind;
  logic [1:0] req_act;
  logic [1:0] req_bs;
  logic [7:0] req_data;
  logic req_ready;
  logic [7:0] rsp_data;
  logic rsp_valid;
  logic ser_enabled;
  logic [7:0] lock_bits;
  logic [7:0] ee [4];
  logic [7:0] fl [8];
  logic [7:0] fu [3];
  logic [7:0] lk;
  logic [7:0] lk2;
  note_t exp_q [$];
  int err_count;
  int tests_run;

  prog_port_if pins();
  prog_port_dev i_prog_port_dev (.clk_sys(clk_sys), .rst(rst), .pins(pins.device),
    .ser_enabled(ser_enabled), .lock_bits(lock_bits));
  prog_port_host i_prog_port_host (.clk_sys(clk_sys), .rst(rst), .pins(pins.host), .req_valid(req_valid),
    .req_kind(req_kind), .req_act(req_act), .req_bs(req_bs), .req_data(req_data), .req_ready(req_ready),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid));
  prog_port_checker u_chk (.clk_sys(clk_sys), .rst(rst), .strobe_clock_in(pins.strobe_clock_in),
    .action_sel_hi(pins.action_sel_hi), .action_sel_lo(pins.action_sel_lo), .wr_n(pins.wr_n),
    .oe_n(pins.oe_n), .data_bus(pins.data_bus), .data_host_oe(pins.data_host_oe),
    .data_dev_oe(pins.data_dev_oe), .done_flag(pins.done_flag));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // One request, held until taken
  task automatic do_req(input logic [2:0] k, input logic [1:0] a, input logic [1:0] b, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_kind <= k;
    req_act <= a;
    req_bs <= b;
    req_data <= d;
    @(negedge clk_sys);
    while (req_ready !== 1'b1 && n < 2000) begin
      n++;
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
    req_valid <= 1'b0;
    // Wait until the host has finished the transfer
    @(negedge clk_sys);
    while (req_ready !== 1'b1 && n < 2000) begin
      n++;
      @(negedge clk_sys);
    end
    if (n >= 2000) err_count++;
  endtask : do_req

  task automatic ld(input logic [1:0] a, input logic [1:0] b, input logic [7:0] d);
    do_req(3'h0, a, b, d);
  endtask : ld

  task automatic rd(input string name, input logic [1:0] b, input logic [7:0] e);
    exp_q.push_back('{name, e});
    do_req(3'h3, ACT_IDLE, b, 8'h00);
  endtask : rd

  always @(posedge clk_sys) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected read", rsp_data, 8'hXX);
      end else begin
        check(exp_q[0].name, rsp_data, exp_q[0].v);
        void'(exp_q.pop_front());
      end
    end
  end

  initial begin
    #(4 * 60000);
    err_count++;
    report_and_stop();
  end

  initial begin
    int n;
    rst = 1'b1;
    req_valid = 1'b0;
    req_kind = 3'h0;
    req_act = ACT_IDLE;
    req_bs = 2'h0;
    req_data = 8'h00;
    err_count = 0;
    tests_run = 0;
    void'($urandom(32'h1FE9));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    // Status after reset
    ld(ACT_CMD, 2'h0, CMD_RD_FUSE);
    rd("fuse lo rst", 2'h0, FUSE_LO_RST);
    rd("fuse hi rst", 2'h3, FUSE_HI_RST);
    rd("fuse ext rst", 2'h1, FUSE_EXT_RST);
    rd("lock rst", 2'h2, LOCK_RST);
    // Fuse writes, selects low, high, extended
    ld(ACT_CMD, 2'h0, CMD_WR_FUSE);
    for (int i = 0; i < 3; i++) begin
      fu[i] = 8'($urandom());
      ld(ACT_DATA, 2'h0, fu[i]);
      do_req(3'h2, ACT_IDLE, (i == 0) ? 2'h0 : ((i == 1) ? 2'h2 : 2'h1), 8'h00);
    end
    // Lock writes, bits only program
    lk = 8'($urandom());
    lk2 = 8'($urandom());
    ld(ACT_CMD, 2'h0, CMD_WR_LOCK);
    ld(ACT_DATA, 2'h0, lk);
    do_req(3'h2, ACT_IDLE, 2'h0, 8'h00);
    check("lock bits", lock_bits, lk);
    ld(ACT_DATA, 2'h0, 8'hFF);
    do_req(3'h2, ACT_IDLE, 2'h0, 8'h00);
    check("lock after erase try", lock_bits, lk);
    ld(ACT_DATA, 2'h0, lk2);
    do_req(3'h2, ACT_IDLE, 2'h0, 8'h00);
    check("lock accumulate", lock_bits, lk & lk2);
    ld(ACT_CMD, 2'h0, CMD_RD_FUSE);
    rd("fuse lo", 2'h0, fu[0]);
    rd("fuse hi", 2'h3, fu[1]);
    rd("fuse ext", 2'h1, fu[2]);
    rd("lock", 2'h2, lk & lk2);
    // EEPROM page write
    ld(ACT_CMD, 2'h0, CMD_WR_EEPROM);
    ld(ACT_ADDR, 2'h2, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ee[i] = 8'($urandom());
      ld(ACT_ADDR, 2'h0, 8'h24 + 8'(i));
      ld(ACT_DATA, 2'h0, ee[i]);
      do_req(3'h1, ACT_IDLE, 2'h0, 8'h00);
    end
    do_req(3'h2, ACT_IDLE, 2'h0, 8'h00);
    // Flash page write, then no-operation
    ld(ACT_CMD, 2'h0, CMD_WR_FLASH);
    for (int i = 0; i < 4; i++) begin
      fl[2 * i] = 8'($urandom());
      fl[2 * i + 1] = 8'($urandom());
      ld(ACT_ADDR, 2'h0, 8'h08 + 8'(i));
      ld(ACT_DATA, 2'h0, fl[2 * i]);
      ld(ACT_DATA, 2'h2, fl[2 * i + 1]);
      do_req(3'h1, ACT_IDLE, 2'h2, 8'h00);
    end
    ld(ACT_ADDR, 2'h2, 8'h01);
    do_req(3'h2, ACT_IDLE, 2'h0, 8'h00);
    ld(ACT_CMD, 2'h0, CMD_NOP);
    // Reads with command and high address loaded once
    ld(ACT_CMD, 2'h0, CMD_RD_EEPROM);
    ld(ACT_ADDR, 2'h2, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ld(ACT_ADDR, 2'h0, 8'h24 + 8'(i));
      rd("eeprom", 2'h0, ee[i]);
    end
    ld(ACT_CMD, 2'h0, CMD_RD_FLASH);
    ld(ACT_ADDR, 2'h2, 8'h01);
    for (int i = 0; i < 4; i++) begin
      ld(ACT_ADDR, 2'h0, 8'h08 + 8'(i));
      rd("flash lo", 2'h0, fl[2 * i]);
      rd("flash hi", 2'h2, fl[2 * i + 1]);
    end
    // Identification and calibration
    ld(ACT_CMD, 2'h0, CMD_RD_ID);
    for (int i = 0; i < 3; i++) begin
      ld(ACT_ADDR, 2'h0, 8'(i));
      rd("id", 2'h0, (i == 0) ? ID_BYTE0 : ((i == 1) ? ID_BYTE1 : ID_BYTE2));
    end
    rd("calibration", 2'h2, CAL_BYTE);
    n = 0;
    while (exp_q.size() != 0 && n < 200) begin
      n++;
      @(posedge clk_sys);
    end
    check("pending reads", 8'(exp_q.size()), 8'h00);
    // Serial enable: wrong byte order refused, right order accepted, reset release clears it
    do_req(3'h4, ACT_IDLE, 2'h0, SER_EN_B2);
    do_req(3'h4, ACT_IDLE, 2'h0, SER_EN_B1);
    repeat (4) @(posedge clk_sys);
    check("serial enable order", {7'h00, ser_enabled}, 8'h00);
    do_req(3'h5, ACT_IDLE, 2'h0, 8'h00);
    do_req(3'h4, ACT_IDLE, 2'h0, SER_EN_B1);
    do_req(3'h4, ACT_IDLE, 2'h0, SER_EN_B2);
    repeat (4) @(posedge clk_sys);
    check("serial enable", {7'h00, ser_enabled}, 8'h01);
    do_req(3'h5, ACT_IDLE, 2'h0, 8'h00);
    repeat (4) @(posedge clk_sys);
    check("serial reset", {7'h00, ser_enabled}, 8'h00);
    report_and_stop();
  end
endmodule : parallel_prog_port_tb_top
`default_nettype wire

// ==== tb/prog_port_checker.sv ====
// Pin-level checks on the programming port between programmer and device
`timescale 1ns/100ps
`default_nettype none
module prog_port_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic strobe_clock_in,
  input wire logic action_sel_hi,
  input wire logic action_sel_lo,
  input wire logic wr_n,
  input wire logic oe_n,
  input wire logic [7:0] data_bus,
  input wire logic data_host_oe,
  input wire logic data_dev_oe,
  input wire logic done_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  oe_follow_a: assert property ($fell(oe_n) |-> ##[1:4] data_dev_oe)
    else $error("device did not drive data after output gate low");
  oe_release_a: assert property ($rose(oe_n) |-> ##[1:4] !data_dev_oe)
    else $error("device kept driving after output gate high");
  no_drive_a: assert property (oe_n && $past(oe_n, 4) |-> !data_dev_oe)
    else $error("device drove data with output gate high");
  bus_fight_a: assert property (!(data_dev_oe && data_host_oe))
    else $error("both ends drive the data bus");
  busy_start_a: assert property ($fell(wr_n) && done_flag |-> ##[1:6] !done_flag)
    else $error("ready flag did not drop after program pulse");
  busy_len_a: assert property ($fell(done_flag) |-> (!done_flag) [*8] ##[6:12] done_flag)
    else $error("busy time out of range");
  wait_ready_a: assert property ($fell(wr_n) |-> done_flag)
    else $error("program pulse issued while busy");
  pulse_len_a: assert property ($fell(wr_n) |-> (!wr_n) [*3])
    else $error("program pulse too short");
  act_hold_a: assert property (strobe_clock_in |-> $stable({action_sel_hi, action_sel_lo, data_bus}))
    else $error("action or data changed during strobe");
  cover property ($fell(done_flag));
endmodule : prog_port_checker
`default_nettype wire
